// ---- src/tsp_phy_enable.sv ----
// module: superspeed phy enable decode for a type-c upstream port
// Notes on behaviour
// [R1] attach-plus-orientation style enables exactly one phy, gated by attach
// [R2] strap low: orientation 1 picks phy b, 0 picks phy a
// [R3] strap high: orientation 1 picks phy a, 0 picks phy b
// [R4] board holds style select high to use per-orientation attach inputs
// [R5] per-orientation style: orientation-a attach asserted turns phy a on
// [R6] per-orientation style: orientation-b attach asserted turns phy b on
// [R7] deasserted per-orientation attach keeps that phy off
// [R8] strap low: all attach and orientation inputs active high
// [R9] strap high: all attach and orientation inputs active low
// [R10] polarity strap pulled down inside, so unconnected means active high; the strap port has no pull-down here, so an undriven strap reads z
// [R11] style select low uses attach plus orientation, high per-orientation
// [R12] attach style enables phy only while adjusted attach is valid
// [R13] inputs synchronised first; all enables held low during reset
module tsp_phy_enable import tsp_pkg::*; #(
    parameter int NUM_ATTACH = TSP_NUM_ATTACH
) (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_in,
    // attach-plus-orientation style inputs
    input wire logic [NUM_ATTACH-1:0] attach_in,
    input wire logic orientation_select_in,
    // per-orientation style inputs
    input wire logic orient_a_attach_in,
    input wire logic orient_b_attach_in,
    // straps
    input wire logic attach_polarity_strap,
    input wire logic control_style_select,
    // phy enables and attach state
    output logic phy_a_enable_out,
    output logic phy_b_enable_out,
    output logic [NUM_ATTACH-1:0] attach_active_out
);
    // refused at elaboration, the or-tree is sized for up to eight
    generate
        if (NUM_ATTACH < 1 || NUM_ATTACH > 8) begin : g_bad_attach
            $error("NUM_ATTACH must lie in 1..8");
        end
    endgenerate

    typedef struct packed {
        tsp_state_t state;
        logic phy_a_en;
        logic phy_b_en;
        logic [NUM_ATTACH-1:0] attach_act;
    } tsp_top_state_t;

    tsp_top_state_t state_reg;
    tsp_top_state_t state_next;

    tsp_sync_if #(.NUM_ATTACH(NUM_ATTACH)) sync_bus ();

    // [R13] input synchronisers
    tsp_sync #(.NUM_ATTACH(NUM_ATTACH)) u_sync (
        .clk_in(sys_clk_in),
        .rst_in(rst_in),
        .attach_in(attach_in),
        .orient_in(orientation_select_in),
        .orient_a_attach_in(orient_a_attach_in),
        .orient_b_attach_in(orient_b_attach_in),
        .polarity_in(attach_polarity_strap),
        .style_in(control_style_select),
        .sync_out(sync_bus.src)
    );

    logic [NUM_ATTACH-1:0] attach_adj;
    logic orient_adj;
    logic orient_a_adj;
    logic orient_b_adj;
    logic any_attach;

    // [R8] [R9] strap-controlled polarity, one xor per input
    genvar gi;
    generate
        for (gi = 0; gi < NUM_ATTACH; gi++) begin : g_attach
            assign attach_adj[gi] = sync_bus.attach[gi] ^ sync_bus.polarity;
        end
    endgenerate
    // [R10] an undriven strap reads z here, not low, so the xor yields x instead of being a no-op
    assign orient_a_adj = sync_bus.orient_a_attach ^ sync_bus.polarity;
    assign orient_b_adj = sync_bus.orient_b_attach ^ sync_bus.polarity;
    // [R2] [R3] orientation decode inverts with the strap
    assign orient_adj = sync_bus.orient ^ sync_bus.polarity;
    assign any_attach = |attach_adj;

    always_comb begin
        state_next = state_reg;
        state_next.attach_act = attach_adj;
        // [R11] style select picks the input set
        if (sync_bus.style == TSP_STYLE_ATTACH_ORIENT) begin
            // [R1] [R12] one phy only, only while attached
            if (!any_attach) begin
                state_next.state = TSP_ST_IDLE;
            end else if (orient_adj == TSP_ORIENT_SEL_B) begin
                state_next.state = TSP_ST_PHY_B;
            end else begin
                state_next.state = TSP_ST_PHY_A;
            end
            case (state_next.state)
                TSP_ST_PHY_A: begin
                    state_next.phy_a_en = 1'b1;
                    state_next.phy_b_en = 1'b0;
                end
                TSP_ST_PHY_B: begin
                    state_next.phy_a_en = 1'b0;
                    state_next.phy_b_en = 1'b1;
                end
                default: begin
                    state_next.phy_a_en = 1'b0;
                    state_next.phy_b_en = 1'b0;
                end
            endcase
        end else begin
            // [R4] strap held high by the board selects this path
            // [R5] [R6] [R7] each phy follows its own attach;
            // both may be on if the controller asserts both
            state_next.phy_a_en = orient_a_adj;
            state_next.phy_b_en = orient_b_adj;
            state_next.state = TSP_ST_IDLE;
        end
    end

    // [R13] enables forced off in reset
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_reg.state <= TSP_ST_IDLE;
            state_reg.phy_a_en <= TSP_EN_RST;
            state_reg.phy_b_en <= TSP_EN_RST;
            state_reg.attach_act <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign phy_a_enable_out = state_reg.phy_a_en;
    assign phy_b_enable_out = state_reg.phy_b_en;
    assign attach_active_out = state_reg.attach_act;
endmodule : tsp_phy_enable

// ---- src/tsp_pkg.sv ----
// package: constants and types for the type-c phy enable block
package tsp_pkg;
    // synchroniser depth in flops
    localparam int TSP_SYNC_STAGES = 2;
    // attach input count (mode 1), default three
    localparam int TSP_NUM_ATTACH = 3;
    // reset values
    localparam logic TSP_EN_RST = 1'b0;
    localparam logic TSP_SYNC_RST = 1'b0;
    // orientation decode when polarity strap low
    localparam logic TSP_ORIENT_SEL_B = 1'b1;
    // control style strap levels
    localparam logic TSP_STYLE_ATTACH_ORIENT = 1'b0;
    localparam logic TSP_STYLE_PER_ORIENT = 1'b1;

    typedef enum logic [1:0] {
        TSP_ST_IDLE,
        TSP_ST_PHY_A,
        TSP_ST_PHY_B
    } tsp_state_t;
endpackage : tsp_pkg

// ---- src/tsp_sync.sv ----
// module: two-flop synchronisers for all connector-control inputs
module tsp_sync import tsp_pkg::*; #(
    parameter int NUM_ATTACH = TSP_NUM_ATTACH
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // raw inputs
    input wire logic [NUM_ATTACH-1:0] attach_in,
    input wire logic orient_in,
    input wire logic orient_a_attach_in,
    input wire logic orient_b_attach_in,
    input wire logic polarity_in,
    input wire logic style_in,
    // synchronised outputs
    tsp_sync_if.src sync_out
);
    localparam int W = NUM_ATTACH + 5;

    typedef struct packed {
        logic [W-1:0] stage1;
        logic [W-1:0] stage2;
    } tsp_sync_state_t;

    tsp_sync_state_t state_reg;
    tsp_sync_state_t state_next;
    logic [W-1:0] raw;

    assign raw = {attach_in, orient_in, orient_a_attach_in,
        orient_b_attach_in, polarity_in, style_in};

    // first stage feeds only the second stage
    always_comb begin
        state_next = state_reg;
        state_next.stage1 = raw;
        state_next.stage2 = state_reg.stage1;
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_reg <= '{default: {W{TSP_SYNC_RST}}};
        end else begin
            state_reg <= state_next;
        end
    end

    assign {sync_out.attach, sync_out.orient, sync_out.orient_a_attach,
        sync_out.orient_b_attach, sync_out.polarity,
        sync_out.style} = state_reg.stage2;
endmodule : tsp_sync

// ---- src/tsp_sync_if.sv ----
// interface: synchronised input bundle between synchroniser and decoder
interface tsp_sync_if #(parameter int NUM_ATTACH = 3);
    logic [NUM_ATTACH-1:0] attach;
    logic orient;
    logic orient_a_attach;
    logic orient_b_attach;
    logic polarity;
    logic style;
    modport src (output attach, orient, orient_a_attach, orient_b_attach,
        polarity, style);
    modport dst (input attach, orient, orient_a_attach, orient_b_attach,
        polarity, style);
endinterface : tsp_sync_if

// ---- tb/tsp_cc_model.sv ----
// model: connector controller driving pins in strapped polarity
module tsp_cc_model (
    // wanted state, active high
    input wire logic [9:0] want_in,
    // pins to the hub
    output logic [7:0] pin_out
);
    timeunit 1ns;
    timeprecision 1ps;
    wire pol = want_in[8];
    // inverted when strapped, style held by board
    assign pin_out = {want_in[9], pol, want_in[7:2] ^ {6{pol}}};
endmodule : tsp_cc_model

// ---- tb/tsp_phy_enable_properties.sv ----
// checker: port timing of the phy enable block
module tsp_phy_enable_properties import tsp_pkg::*; #(
    parameter int NUM_ATTACH = TSP_NUM_ATTACH
) (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_in,
    // watched ports
    input wire logic [NUM_ATTACH-1:0] attach_in,
    input wire logic orientation_select_in,
    input wire logic orient_a_attach_in,
    input wire logic orient_b_attach_in,
    input wire logic attach_polarity_strap,
    input wire logic control_style_select,
    input wire logic phy_a_enable_out,
    input wire logic phy_b_enable_out,
    input wire logic [NUM_ATTACH-1:0] attach_active_out
);
    logic [1:0] warm_reg;
    wire pol = attach_polarity_strap;
    wire [NUM_ATTACH-1:0] adj = attach_in ^ {NUM_ATTACH{pol}};
    wire ori = orientation_select_in ^ pol;
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);
    // outputs lag inputs by three edges after release
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) warm_reg <= 2'h0;
        else if (warm_reg != 2'h3) warm_reg <= warm_reg + 2'h1;
    end
    sequence s_m1;
        warm_reg == 2'h3 && !$past(control_style_select, 3);
    endsequence
    sequence s_m2;
        warm_reg == 2'h3 && $past(control_style_select, 3);
    endsequence
    property p_warm;
        warm_reg != 2'h3 |-> !phy_a_enable_out && !phy_b_enable_out;
    endproperty
    property p_m1_a;
        s_m1 |-> phy_a_enable_out == ($past(|adj, 3) && !$past(ori, 3));
    endproperty
    property p_m1_b;
        s_m1 |-> phy_b_enable_out == ($past(|adj, 3) && $past(ori, 3));
    endproperty
    property p_m1_one;
        s_m1 ##0 $past(|adj, 3) |-> phy_a_enable_out ^ phy_b_enable_out;
    endproperty
    property p_m1_idle;
        s_m1 ##0 !$past(|adj, 3) |-> !phy_a_enable_out && !phy_b_enable_out;
    endproperty
    property p_m2_a;
        s_m2 |-> phy_a_enable_out == $past(orient_a_attach_in ^ pol, 3);
    endproperty
    property p_m2_b;
        s_m2 |-> phy_b_enable_out == $past(orient_b_attach_in ^ pol, 3);
    endproperty
    property p_active;
        warm_reg == 2'h3 |-> attach_active_out == $past(adj, 3);
    endproperty
    a_warm: assert property (p_warm) else $error("enable in warmup");
    a_m1_a: assert property (p_m1_a) else $error("phy a decode");
    a_m1_b: assert property (p_m1_b) else $error("phy b decode");
    a_m1_one: assert property (p_m1_one) else $error("not one phy");
    a_m1_idle: assert property (p_m1_idle) else $error("phy on idle");
    a_m2_a: assert property (p_m2_a) else $error("orient a phy");
    a_m2_b: assert property (p_m2_b) else $error("orient b phy");
    a_active: assert property (p_active) else $error("attach state");
endmodule : tsp_phy_enable_properties
bind tsp_phy_enable tsp_phy_enable_properties #(.NUM_ATTACH(NUM_ATTACH))
    tsp_phy_enable_properties_i (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
    .attach_in(attach_in), .orientation_select_in(orientation_select_in),
    .orient_a_attach_in(orient_a_attach_in),
    .orient_b_attach_in(orient_b_attach_in),
    .attach_polarity_strap(attach_polarity_strap),
    .control_style_select(control_style_select),
    .phy_a_enable_out(phy_a_enable_out), .phy_b_enable_out(phy_b_enable_out),
    .attach_active_out(attach_active_out));

// ---- tb/tsp_phy_enable_test.sv ----
// testbench: connector state table, then reset checks
module tsp_phy_enable_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [9:0] row = 10'h000;
    logic [7:0] pin;
    logic pa, pb;
    logic [2:0] act;
    int error_cnt = 0;
    int samples_checked = 0;
    int cyc = 0;
    // {style, strap, attach, orient, a, b, phy a, phy b}
    logic [9:0] rows [9] = '{10'h031, 10'h082, 10'h01c, 10'h151, 10'h122,
        10'h20a, 10'h2f5, 10'h31f, 10'h300};
    always #2.5 sys_clk_in = ~sys_clk_in;
    tsp_cc_model tsp_cc_model_i (.want_in(row), .pin_out(pin));
    tsp_phy_enable tsp_phy_enable_i (.sys_clk_in(sys_clk_in),
        .rst_in(rst_in), .attach_in(pin[5:3]),
        .orientation_select_in(pin[2]), .orient_a_attach_in(pin[1]),
        .orient_b_attach_in(pin[0]),
        .attach_polarity_strap(pin[6]), .control_style_select(pin[7]),
        .phy_a_enable_out(pa), .phy_b_enable_out(pb),
        .attach_active_out(act));
    task automatic chk_bit(input string nm, input logic e, input logic g);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value %s expected %b seen %b", nm, e, g);
        end
    endtask : chk_bit
    task automatic chk_vec(input string nm, input logic [2:0] e,
        input logic [2:0] g);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_vec
    task automatic give_verdict();
        $display("checked %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : give_verdict
    always @(posedge sys_clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 500) begin
            error_cnt++;
            give_verdict();
        end
    end
    initial begin
        repeat (16) @(posedge sys_clk_in);
        rst_in <= 1'b0;
        foreach (rows[i]) begin
            row <= rows[i];
            repeat (4) @(posedge sys_clk_in);
            #1;
            chk_bit("phy_a", rows[i][1], pa);
            chk_bit("phy_b", rows[i][0], pb);
            chk_vec("attach_active", rows[i][7:5], act);
        end
        @(posedge sys_clk_in);
        row <= 10'h031;
        rst_in <= 1'b1;
        repeat (3) @(posedge sys_clk_in);
        #1;
        chk_bit("phy_b in reset", 1'b0, pb);
        chk_vec("active in reset", 3'h0, act);
        @(posedge sys_clk_in);
        rst_in <= 1'b0;
        repeat (2) @(posedge sys_clk_in);
        #1;
        chk_bit("phy_b syncing", 1'b0, pb);
        @(posedge sys_clk_in);
        #1;
        chk_bit("phy_b after sync", 1'b1, pb);
        chk_vec("active after sync", 3'h1, act);
        give_verdict();
    end
endmodule : tsp_phy_enable_test
